// file: elc_pkg.sv
package elc_pkg;
   // register offsets on the plain register port
   localparam logic [7:0] OFF_BREAK_STATUS  = 8'h00;
   localparam logic [7:0] OFF_BREAK_FLAG_CR = 8'h01;
   localparam logic [7:0] OFF_CONFIG        = 8'h02;
   localparam logic [7:0] OFF_IRQ_ENABLE    = 8'h03;
   // field positions
   localparam int BIT_STOPWAIT_FLAG = 1;
   localparam int BIT_CLEAR_ENABLE  = 7;
   localparam int BIT_SHORT_REC     = 0;
   localparam int BIT_WDOG_DISABLE  = 1;
   // reset values
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
   localparam logic [1:0] RST_CONFIG     = 2'h0;
   // stop recovery counts in oscillator cycles
   localparam int STOP_REC_LONG  = 4096;
   localparam int STOP_REC_SHORT = 32;
   localparam logic [12:0] STOP_REC_SHORT_CNT = 13'(STOP_REC_SHORT);
   // number of hardware interrupt sources
   localparam int NUM_IRQ = 8;
   // vector selectors
   localparam logic [3:0] VEC_SWI   = 4'hF;
   localparam logic [3:0] VEC_RESET = 4'hE;
   // controller states
   typedef enum logic [5:0] {
      ST_RUN     = 6'h01,
      ST_STACK   = 6'h02,
      ST_UNSTACK = 6'h04,
      ST_WAIT    = 6'h08,
      ST_STOP    = 6'h10,
      ST_RECOVER = 6'h20
   } elc_state_e;
endpackage : elc_pkg

// file: elc_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
// fixed priority: lower index wins
module elc_arbiter (
   input  wire logic [elc_pkg::NUM_IRQ-1:0] req,
   output logic                             any,
   output logic [3:0]                       idx
);
   // scan from lowest priority upward so the highest ends last
   always_comb begin
      any = 1'b0;
      idx = 4'h0;
      for (int i = elc_pkg::NUM_IRQ - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = 4'(i);
         end
      end
   end
endmodule : elc_arbiter
`default_nettype wire

// file: elc_core.sv
`timescale 1ns/100ps
`default_nettype none
module elc_core #(
   parameter int STOP_REC_LONG_CYC = elc_pkg::STOP_REC_LONG
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   // register port
   input  wire logic [7:0]                  reg_addr,
   input  wire logic [7:0]                  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [7:0]                  reg_rdata,
   // core handshake
   input  wire logic                        instr_done,
   input  wire logic                        swi_exec,
   input  wire logic                        rti_exec,
   input  wire logic                        wait_exec,
   input  wire logic                        stop_exec,
   input  wire logic                        stack_done,
   input  wire logic                        mask_bit,
   input  wire logic [15:0]                 pc_value,
   // peripheral side
   input  wire logic [elc_pkg::NUM_IRQ-1:0] irq_req,
   input  wire logic                        break_req,
   input  wire logic                        flag_clear_req,
   // outputs to core
   output logic                             stack_start,
   output logic                             unstack_start,
   output logic                             set_mask,
   output logic                             clear_mask,
   output logic      [3:0]                  vector_sel,
   output logic      [15:0]                 stacked_pc,
   output logic                             stack_index_high,
   output logic                             cpu_clk_en,
   output logic                             bus_clk_en,
   output logic                             osc_clk_en,
   output logic                             prescale_clr,
   output logic                             watchdog_run,
   output logic                             flag_clear_allow,
   output logic                             in_break
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   elc_pkg::elc_state_e state_r;               // controller state
   logic [12:0]         pre_cnt_r;             // prescale counter
   logic                sw_flag_r;             // break stop/wait flag
   logic                clr_en_r;              // break clear enable bit
   logic [1:0]          cfg_r;                 // short recovery, wdog off
   logic [7:0]          irq_en_r;              // per source enables
   logic                latched_r;             // interrupt latched
   logic [3:0]          latch_idx_r;           // latched source
   logic                brk_r;                 // in break state
   logic                swi_pend_r;            // software entry pending
   logic [7:0]          rdata_nxt;             // read mux
   logic [elc_pkg::NUM_IRQ-1:0] qual;          // enabled requests
   logic                arb_any;               // any enabled request
   logic [3:0]          arb_idx;               // winner
   logic [12:0]         rec_target;            // selected delay
   logic                lowpwr;                // wait or stop
   logic                wake;                  // exit event
   logic                sw_wr;                 // write to status

   ////////////////////////////////////////////////////////////////////////
   // arbitration
   // source enable qualifies request
   assign qual = irq_req & irq_en_r;

   elc_arbiter u_arb (
      .req (qual),
      .any (arb_any),
      .idx (arb_idx)
   );

   assign lowpwr = (state_r == elc_pkg::ST_WAIT) ||
                   (state_r == elc_pkg::ST_STOP);
   assign wake   = arb_any || break_req;

   assign rec_target = cfg_r[elc_pkg::BIT_SHORT_REC] ?
                       elc_pkg::STOP_REC_SHORT_CNT :
                       13'(STOP_REC_LONG_CYC);

   ////////////////////////////////////////////////////////////////////////
   // main sequencer; reset is synchronous and outranks everything
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r <= elc_pkg::ST_RUN;
      end else begin
         case (state_r)
            elc_pkg::ST_RUN: begin
               if (instr_done) begin
                  if (stop_exec) begin
                     state_r <= elc_pkg::ST_STOP;
                  end else if (wait_exec) begin
                     state_r <= elc_pkg::ST_WAIT;
                  end else if (rti_exec) begin
                     state_r <= elc_pkg::ST_UNSTACK;
                  end else if (swi_exec || break_req) begin
                     state_r <= elc_pkg::ST_STACK;
                  end else if ((arb_any || latched_r) && !mask_bit) begin
                     state_r <= elc_pkg::ST_STACK;
                  end
               end
            end
            elc_pkg::ST_STACK: begin
               if (stack_done) begin
                  state_r <= elc_pkg::ST_RUN;
               end
            end
            elc_pkg::ST_UNSTACK: begin
               // pending one goes straight back to stacking
               if (stack_done) begin
                  if (arb_any) begin
                     state_r <= elc_pkg::ST_STACK;
                  end else begin
                     state_r <= elc_pkg::ST_RUN;
                  end
               end
            end
            elc_pkg::ST_WAIT: begin
               if (wake) begin
                  state_r <= elc_pkg::ST_STACK;
               end
            end
            elc_pkg::ST_STOP: begin
               if (wake) begin
                  state_r <= elc_pkg::ST_RECOVER;
               end
            end
            elc_pkg::ST_RECOVER: begin
               if (pre_cnt_r >= rec_target - 13'h0001) begin
                  state_r <= elc_pkg::ST_STACK;
               end
            end
            default: begin
               state_r <= elc_pkg::ST_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // prescale counter; cleared in stop so recovery starts at zero
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pre_cnt_r <= 13'h0000;
      end else if (state_r == elc_pkg::ST_STOP) begin
         pre_cnt_r <= 13'h0000;
      end else begin
         pre_cnt_r <= pre_cnt_r + 13'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt latch; holds the winner until serviced or mask clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         latched_r   <= 1'b0;
         latch_idx_r <= 4'h0;
      end else if (stack_done && state_r == elc_pkg::ST_STACK) begin
         latched_r <= 1'b0;
      end else if (latched_r && !mask_bit && state_r == elc_pkg::ST_RUN &&
                   !instr_done) begin
         latched_r <= 1'b0;
      end else if (!latched_r && arb_any) begin
         latched_r   <= 1'b1;
         latch_idx_r <= arb_idx;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software/break entry memory for vector select
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         swi_pend_r <= 1'b0;
      end else if (state_r == elc_pkg::ST_RUN && instr_done &&
                   (swi_exec || break_req)) begin
         swi_pend_r <= 1'b1;
      end else if (lowpwr && break_req) begin
         swi_pend_r <= 1'b1;
      end else if (stack_done && state_r == elc_pkg::ST_STACK) begin
         swi_pend_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // break state follows the break module output
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         brk_r <= 1'b0;
      end else begin
         brk_r <= break_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // break stop/wait flag; set wins over a same-cycle clear
   assign sw_wr = reg_wr && (reg_addr == elc_pkg::OFF_BREAK_STATUS) &&
                  !reg_wdata[elc_pkg::BIT_STOPWAIT_FLAG];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sw_flag_r <= 1'b0;
      end else if (lowpwr && break_req) begin
         sw_flag_r <= 1'b1;
      end else if (sw_wr) begin
         sw_flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers written by software
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         clr_en_r <= 1'b0;
         cfg_r    <= elc_pkg::RST_CONFIG;
         irq_en_r <= elc_pkg::RST_IRQ_ENABLE;
      end else if (reg_wr) begin
         if (reg_addr == elc_pkg::OFF_BREAK_FLAG_CR) begin
            clr_en_r <= reg_wdata[elc_pkg::BIT_CLEAR_ENABLE];
         end
         if (reg_addr == elc_pkg::OFF_CONFIG) begin
            cfg_r <= reg_wdata[1:0];
         end
         if (reg_addr == elc_pkg::OFF_IRQ_ENABLE) begin
            irq_en_r <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped reads return zero
   always_comb begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         elc_pkg::OFF_BREAK_STATUS:
            rdata_nxt[elc_pkg::BIT_STOPWAIT_FLAG] = sw_flag_r;
         elc_pkg::OFF_BREAK_FLAG_CR:
            rdata_nxt[elc_pkg::BIT_CLEAR_ENABLE] = clr_en_r;
         elc_pkg::OFF_CONFIG:
            rdata_nxt[1:0] = cfg_r;
         elc_pkg::OFF_IRQ_ENABLE:
            rdata_nxt = irq_en_r;
         default:
            rdata_nxt = 8'h00;
      endcase
   end

   // read data valid only the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data outputs to the core
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         vector_sel <= elc_pkg::VEC_RESET;
         stacked_pc <= 16'h0000;
      end else if (state_r != elc_pkg::ST_STACK) begin
         if (swi_exec || break_req || swi_pend_r) begin
            vector_sel <= elc_pkg::VEC_SWI;
            stacked_pc <= pc_value;
         end else begin
            vector_sel <= latched_r ? latch_idx_r : arb_idx;
            stacked_pc <= pc_value - 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // handshake and clock controls
   // stacking sets mask; return restores
   assign stack_start   = (state_r == elc_pkg::ST_STACK);
   assign set_mask      = (state_r == elc_pkg::ST_STACK);
   assign unstack_start = (state_r == elc_pkg::ST_UNSTACK);
   assign stack_index_high = 1'b0;
   assign clear_mask = (state_r == elc_pkg::ST_RUN) && instr_done &&
                       (wait_exec || stop_exec);
   // core unclocked in wait and stop
   assign cpu_clk_en = !lowpwr && (state_r != elc_pkg::ST_RECOVER);
   // both generator outputs off in stop
   assign bus_clk_en = (state_r != elc_pkg::ST_STOP) &&
                       (state_r != elc_pkg::ST_RECOVER);
   assign osc_clk_en = (state_r != elc_pkg::ST_STOP);
   assign prescale_clr = (state_r == elc_pkg::ST_STOP);
   // watchdog runs in wait unless disabled
   assign watchdog_run = !cfg_r[elc_pkg::BIT_WDOG_DISABLE] &&
                         (state_r != elc_pkg::ST_STOP);
   // flag clears blocked in break unless enabled
   // a permitted clear simply goes through and sticks
   // second step of a two-step clear is gated here too
   assign flag_clear_allow = flag_clear_req && (!brk_r || clr_en_r);
   assign in_break = brk_r;

   ////////////////////////////////////////////////////////////////////////
   // checks on what this block drives; reset quiets them all
   default clocking cb_chk @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_swi_bnd; (state_r == elc_pkg::ST_RUN) && instr_done && swi_exec && !stop_exec && !wait_exec && !rti_exec; endsequence
   sequence s_brk_lowpwr; lowpwr && break_req; endsequence
   chk_swi_entry: assert property (s_swi_bnd |=> stack_start)
      else $error("software interrupt did not start stacking");
   chk_mask_block: assert property ((state_r == elc_pkg::ST_RUN) && mask_bit && !swi_exec && !break_req && !rti_exec && !wait_exec && !stop_exec |=> !stack_start)
      else $error("masked request started stacking");
   chk_index_high: assert property (!stack_index_high)
      else $error("index high register requested on stack");
   chk_stop_clocks: assert property ((state_r == elc_pkg::ST_STOP) |-> !osc_clk_en && !bus_clk_en && !cpu_clk_en)
      else $error("clock left running in stop");
   chk_break_guard: assert property (brk_r && !clr_en_r |-> !flag_clear_allow)
      else $error("flag clear let through in break");
   chk_break_flag: assert property (s_brk_lowpwr |=> sw_flag_r)
      else $error("break exit from low power left flag clear");
   chk_prescale_hold: assert property ((state_r == elc_pkg::ST_STOP) |=> pre_cnt_r == 13'h0000)
      else $error("prescale counter not held in stop");
endmodule : elc_core
`default_nettype wire

// file: elc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// stand-in for the processor core: answers push and pull requests
// promptly or slowly, and keeps its own copy of the interrupt mask
module elc_cpu_model (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic slow,          // stretch every push or pull
   input  wire logic stack_start,
   input  wire logic unstack_start,
   input  wire logic set_mask,
   input  wire logic clear_mask,
   output logic      stack_done,
   output logic      mask_bit
);
   logic [2:0] cnt_r;               // cycles spent on current transfer
   ////////////////////////////////////////////////////////////////////
   // one-cycle done pulse after 1 or 5 cycles of work
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !(stack_start || unstack_start) || stack_done) begin
         cnt_r      <= 3'h0;
         stack_done <= 1'b0;
      end else begin
         cnt_r      <= cnt_r + 3'h1;
         stack_done <= (cnt_r == (slow ? 3'h4 : 3'h0));
      end
   end
   ////////////////////////////////////////////////////////////////////
   // mask set on entry, dropped by low-power entry and by the pull;
   // the pull restores an unmasked state since callers ran unmasked
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mask_bit <= 1'b0;
      end else if (set_mask) begin
         mask_bit <= 1'b1;
      end else if (clear_mask || (unstack_start && stack_done)) begin
         mask_bit <= 1'b0;
      end
   end
endmodule : elc_cpu_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        ref_clk, rst_n, reg_wr, reg_rd, instr_done, swi_exec;
   logic        rti_exec, wait_exec, stop_exec, stack_done, mask_bit;
   logic        break_req, flag_clear_req, slow, stack_start;
   logic        unstack_start, set_mask, clear_mask, stack_index_high;
   logic        cpu_clk_en, bus_clk_en, osc_clk_en, prescale_clr;
   logic        watchdog_run, flag_clear_allow, in_break, cm;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, irq_req;
   logic [15:0] pc_value, stacked_pc;
   logic [3:0]  vector_sel;
   logic        rd_d = 1'b0;        // read issued last cycle
   logic        st_d = 1'b0;        // push request seen last cycle
   logic [7:0]  rd_q[$];            // expected read data
   logic [20:0] ent_q[$];           // {check pc, vector, pc}
   logic [20:0] e;
   int          n_fail = 0, n_compared = 0, seed;

   elc_core #(.STOP_REC_LONG_CYC(64)) u_elc_core (.ref_clk(ref_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_done(instr_done), .swi_exec(swi_exec), .rti_exec(rti_exec),
      .wait_exec(wait_exec), .stop_exec(stop_exec),
      .stack_done(stack_done), .mask_bit(mask_bit), .pc_value(pc_value),
      .irq_req(irq_req), .break_req(break_req),
      .flag_clear_req(flag_clear_req), .stack_start(stack_start),
      .unstack_start(unstack_start), .set_mask(set_mask),
      .clear_mask(clear_mask), .vector_sel(vector_sel),
      .stacked_pc(stacked_pc), .stack_index_high(stack_index_high),
      .cpu_clk_en(cpu_clk_en), .bus_clk_en(bus_clk_en),
      .osc_clk_en(osc_clk_en), .prescale_clr(prescale_clr),
      .watchdog_run(watchdog_run), .flag_clear_allow(flag_clear_allow),
      .in_break(in_break));
   elc_cpu_model u_elc_cpu_model (.ref_clk(ref_clk), .rst_n(rst_n),
      .slow(slow), .stack_start(stack_start),
      .unstack_start(unstack_start), .set_mask(set_mask),
      .clear_mask(clear_mask), .stack_done(stack_done),
      .mask_bit(mask_bit));
   ////////////////////////////////////////////////////////////////////
   // reporting
   task automatic test_done;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   ////////////////////////////////////////////////////////////////////
   // bus and core-side drivers, all launched right after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      rd_q.push_back(x);
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask : rd
   // k = {software, return, wait, stop}; cm keeps the mask-clear seen
   task automatic bnd(input logic [3:0] k);
      @(posedge ref_clk);
      instr_done <= 1'b1;
      {swi_exec, rti_exec, wait_exec, stop_exec} <= k;
      @(posedge ref_clk);
      cm = clear_mask;
      instr_done <= 1'b0;
      {swi_exec, rti_exec, wait_exec, stop_exec} <= 4'h0;
   endtask : bnd
   task automatic hang;
      chk(20'h0, 20'h1);
      test_done();
   endtask : hang
   // bounded wait until no push or pull is under way
   task automatic idle;
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge ref_clk);
         #1;
         if (!stack_start && !unstack_start) break;
      end
      if (i == 200) hang();
   endtask : idle
   task automatic wait_stk(output int n);
      for (n = 0; n < 300; n++) begin
         @(posedge ref_clk);
         #1;
         if (stack_start) break;
      end
      if (n == 300) hang();
   endtask : wait_stk
   function automatic logic [3:0] low_idx(input logic [7:0] v);
      low_idx = 4'h0;
      for (int i = 7; i >= 0; i--) if (v[i]) low_idx = 4'(i);
   endfunction : low_idx
   ////////////////////////////////////////////////////////////////////
   // clock, overall limit, and the watcher that takes notes off queues
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      hang();
   end
   always @(posedge ref_clk) begin
      if (rd_d) begin
         if (rd_q.size() == 0) chk(20'h0, 20'h1);
         else chk(20'(reg_rdata), 20'(rd_q.pop_front()));
      end
      if (stack_start && !st_d) begin
         if (ent_q.size() == 0) chk(20'h0, 20'h1);
         else begin
            e = ent_q.pop_front();
            chk({vector_sel, e[20] ? stacked_pc : e[15:0]}, e[19:0]);
         end
      end
      rd_d <= reg_rd;
      st_d <= stack_start;
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      int n, k;
      logic [15:0] pc;
      logic [7:0]  en, rq;
      seed = 99;
      {rst_n, reg_wr, reg_rd, instr_done, swi_exec, rti_exec} = 6'h0;
      {wait_exec, stop_exec, break_req, flag_clear_req, slow} = 5'h0;
      {reg_addr, reg_wdata, irq_req, pc_value} = 40'h0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (k = 0; k < 5; k++) rd(k == 4 ? 8'h10 : 8'(k), 8'h00);
      wr(elc_pkg::OFF_BREAK_FLAG_CR, 8'h80);
      rd(elc_pkg::OFF_BREAK_FLAG_CR, 8'h80);
      wr(elc_pkg::OFF_CONFIG, 8'h03);
      rd(elc_pkg::OFF_CONFIG, 8'h03);
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h00);
      wr(elc_pkg::OFF_CONFIG, 8'h00);
      wr(elc_pkg::OFF_BREAK_FLAG_CR, 8'h00);
      // random sources and enables, prompt and slow core
      for (k = 0; k < 8; k++) begin
         en = 8'($random(seed));
         rq = 8'($random(seed));
         pc = 16'($random(seed));
         pc_value <= pc;
         slow <= k[0];
         wr(elc_pkg::OFF_IRQ_ENABLE, en);
         irq_req <= rq;
         if ((en & rq) != 8'h00) ent_q.push_back({1'b1, low_idx(en & rq), pc - 16'h1});
         bnd(4'h0);
         idle();
         irq_req <= 8'h00;
         bnd(4'h4);
         idle();
      end
      // a higher source arriving while masked must wait its turn
      wr(elc_pkg::OFF_IRQ_ENABLE, 8'hFF);
      irq_req <= 8'h06;
      ent_q.push_back({1'b1, 4'h1, pc - 16'h1});
      bnd(4'h0);
      idle();
      chk(20'(mask_bit), 20'h1);
      irq_req <= 8'h05;
      bnd(4'h0);
      idle();
      ent_q.push_back({1'b1, 4'hF, pc});
      bnd(4'h8);
      idle();
      ent_q.push_back({1'b1, 4'h0, pc - 16'h1});
      bnd(4'h4);
      idle();
      bnd(4'h0);
      idle();
      irq_req <= 8'h00;
      bnd(4'h4);
      idle();
      // wait mode woken by an enabled source
      wr(elc_pkg::OFF_IRQ_ENABLE, 8'h08);
      bnd(4'h2);
      #1;
      chk({cm, cpu_clk_en, bus_clk_en, watchdog_run}, 20'hB);
      irq_req <= 8'h08;
      ent_q.push_back({1'b1, 4'h3, pc - 16'h1});
      wait_stk(n);
      chk(20'(n < 2), 20'h1);
      irq_req <= 8'h00;
      idle();
      bnd(4'h4);
      idle();
      // wait mode left by break, flag protection inside break
      bnd(4'h2);
      break_req <= 1'b1;
      flag_clear_req <= 1'b1;
      ent_q.push_back({1'b0, 4'hF, 16'h0});
      wait_stk(n);
      chk({stack_index_high, 3'(n < 2), flag_clear_allow}, 20'h2);
      wr(elc_pkg::OFF_BREAK_FLAG_CR, 8'h80);
      #1;
      chk(20'(flag_clear_allow), 20'h1);
      rd(elc_pkg::OFF_BREAK_STATUS, 8'h02);
      wr(elc_pkg::OFF_BREAK_STATUS, 8'h00);
      rd(elc_pkg::OFF_BREAK_STATUS, 8'h00);
      wr(elc_pkg::OFF_BREAK_FLAG_CR, 8'h00);
      break_req <= 1'b0;
      idle();
      @(posedge ref_clk);
      #1;
      chk(20'(flag_clear_allow), 20'h1);
      flag_clear_req <= 1'b0;
      bnd(4'h4);
      idle();
      // stop mode, long then short recovery
      for (k = 0; k < 2; k++) begin
         wr(elc_pkg::OFF_CONFIG, 8'(k));
         wr(elc_pkg::OFF_IRQ_ENABLE, 8'h01);
         bnd(4'h1);
         #1;
         chk({cm, osc_clk_en, bus_clk_en, cpu_clk_en, prescale_clr}, 20'h11);
         ent_q.push_back({1'b1, 4'h0, pc - 16'h1});
         irq_req <= 8'h01;
         wait_stk(n);
         chk(20'(n >= (k ? 32 : 64) && n <= (k ? 34 : 66)), 20'h1);
         irq_req <= 8'h00;
         idle();
         bnd(4'h4);
         idle();
      end
      // reset in mid-entry beats everything and clears the flag
      bnd(4'h2);
      break_req <= 1'b1;
      ent_q.push_back({1'b0, 4'hF, 16'h0});
      wait_stk(n);
      rst_n <= 1'b0;
      break_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({stack_start, vector_sel}, 20'h0E);
      rst_n <= 1'b1;
      rd(elc_pkg::OFF_BREAK_STATUS, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk(20'(ent_q.size()), 20'h0);
      test_done();
   end
endmodule : tb
`default_nettype wire
